// ==== inc/cmx_pkg.sv ====
// Overview of operation
// - Instruction word 16'he52a adds complex vreg5/vreg4 into vreg7/vreg6.
// - Parts are 32-bit; vreg7/vreg6 first operand, vreg5/vreg4 second.
// - The real sum goes to vreg7 and the imaginary sum to vreg6.
// - The second operand is arithmetically shifted right by shift_right_count.
// - With round_enable the shifted-out bits round, otherwise they truncate.
// - With saturate_enable each add result part clamps to signed 32 bits.
// - Add overflow sets real_overflow_flag and imag_overflow_flag per part.
// - The complex add completes in one cycle.
// - Word 16'he50f is the conjugate multiply-accumulate on vreg0..vreg5.
// - First, shifted vreg3 accumulates into vreg5 and vreg2 into vreg4.
// - Multiply operands are two signed halves: bits 31:16 high, 15:0 low.
// - Pack order clear: real hh+ll, imaginary h0*l1 - l0*h1.
// - Pack order set: real ll+hh, imaginary l0*h1 - h0*l1.
// - Product overflow sets real_overflow_flag and imag_overflow_flag.
// - Multiply-accumulate takes two cycles; products land one cycle later.
// - Low word 16'he3f7 with high nibble 1 is the parallel-load form.
// - That form loads load_dest_reg from the memory word concurrently.
package cmx_pkg;

  // Byte offsets on the register bus; vreg n sits at OFF_VREG0 + 4*n.
  localparam logic [7:0] OFF_VREG0   = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h24;
  localparam logic [7:0] OFF_INSTR   = 8'h28;
  localparam logic [7:0] OFF_MEMWORD = 8'h2c;
  localparam int         NUM_VREGS   = 9;

  // Field positions of vector_status.
  localparam int ST_SHIFT_LSB = 0;
  localparam int ST_SHIFT_W   = 5;
  localparam int ST_RND_BIT   = 5;
  localparam int ST_SAT_BIT   = 6;
  localparam int ST_PACK_BIT  = 7;
  localparam int ST_REAL_OVERFLOW_FLAG_BIT  = 8;
  localparam int ST_IMAG_OVERFLOW_FLAG_BIT  = 9;
  localparam int ST_BADOP_BIT = 10;
  localparam int ST_BUSY_BIT  = 16;

  // Reset values.
  localparam logic [31:0] VREG_RST   = 32'h0000_0000;
  localparam logic [31:0] INSTR_RST  = 32'h0000_0000;
  localparam logic [4:0]  SHIFT_RST  = 5'h00;

  // Instruction encodings.
  localparam logic [15:0] OPC_CADD    = 16'he52a;
  localparam logic [15:0] OPC_CMAC    = 16'he50f;
  localparam logic [15:0] OPC_CMAC_LD = 16'he3f7;
  localparam logic [3:0]  OPC_LD_HI   = 4'h1;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    S_IDLE,
    S_ADD,
    S_MAC1,
    S_MAC2
  } cmx_state_t;

  // Clamp a 33-bit signed value to the signed 32-bit range.
  function automatic logic [31:0] sat33(input logic [32:0] v);
    if (v[32] == v[31]) begin
      sat33 = v[31:0];
    end else if (v[32]) begin
      sat33 = 32'h8000_0000;
    end else begin
      sat33 = 32'h7fff_ffff;
    end
  endfunction

endpackage

// ==== hw/cmx_shift_acc.sv ====
`timescale 1ns/1ps
// Adds a shifted, optionally rounded addend to an accumulator with saturation.
module cmx_shift_acc (
  input  wire logic [31:0] acc,
  input  wire logic [31:0] addend,
  input  wire logic [4:0]  shift,
  input  wire logic        rnd_en,
  input  wire logic        sat_en,
  output logic      [31:0] result,
  output logic             ovf
);

  logic [31:0] shifted;
  logic        rbit;
  logic [31:0] rounded;
  logic [32:0] sum;

  // The rounded value cannot overflow: any shift of one or more leaves headroom.
  always_comb begin
    shifted = $signed(addend) >>> shift;
    rbit    = 1'b0;
    if (rnd_en && (shift != 5'h00)) begin
      rbit = addend[shift - 5'h01];
    end
    rounded = shifted + {31'h0, rbit};
    sum     = {acc[31], acc} + {rounded[31], rounded};
    ovf     = sum[32] ^ sum[31];
    result  = sat_en ? cmx_pkg::sat33(sum) : sum[31:0];
  end

endmodule

// ==== hw/cmx_datapath_top.sv ====
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Complex add and conjugate multiply-accumulate datapath with a register port.
module cmx_datapath_top (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  logic [31:0]         vreg_r [0:cmx_pkg::NUM_VREGS-1];
  logic [31:0]         instr_r;
  logic [31:0]         memword_r;
  logic [4:0]          shift_r;
  logic                rnd_r;
  logic                sat_r;
  logic                pack_r;
  logic                real_overflow_flag_r;
  logic                imag_overflow_flag_r;
  logic                badop_r;
  cmx_pkg::cmx_state_t st_r;
  logic [31:0]         prod_re_r;
  logic [31:0]         prod_im_r;
  logic                prod_ovr_r;
  logic                prod_ovi_r;
  logic                aw_held_r;
  logic [7:0]          aw_addr_r;
  logic                w_held_r;
  logic [31:0]         w_data_r;
  logic [3:0]          w_strb_r;
  logic                wr_fire;
  logic                busy;
  logic [5:0]          wr_idx;
  logic                wr_vreg;
  logic                wr_status;
  logic                wr_instr;
  logic                wr_mem;
  logic                wr_ok;
  logic [31:0]         wr_merged;
  logic                op_add;
  logic                op_mac;
  logic                op_mac_ld;
  logic [31:0]         acc_re;
  logic [31:0]         acc_im;
  logic [31:0]         add_re;
  logic [31:0]         add_im;
  logic [31:0]         res_re;
  logic [31:0]         res_im;
  logic                ovf_re;
  logic                ovf_im;
  logic [31:0]         p_hh;
  logic [31:0]         p_ll;
  logic [31:0]         p_hl;
  logic [31:0]         p_lh;
  logic [32:0]         sum_re;
  logic [32:0]         sum_im;
  logic [3:0]          ld_dest;
  logic [31:0]         status_view;

  // Word index of a byte address; the two low bits are ignored.
  function automatic logic [5:0] word_index(input logic [7:0] a);
    word_index = a[7:2];
  endfunction

  // Replace the byte lanes of old that the strobes select.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0]  s);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[8*b +: 8] = d[8*b +: 8];
      end
    end
  endfunction

  // Write address channel; accepted once and held until the write completes.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r     <= 1'b1;
      aw_addr_r     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held_r     <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel; may arrive before or after the address.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r     <= 1'b1;
      w_data_r     <= s_axi_wdata;
      w_strb_r     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held_r     <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Write decode. Vector registers and new instructions are refused while
  // busy, so software can never tear an operand under a running operation.
  always_comb begin
    busy      = (st_r != cmx_pkg::S_IDLE);
    wr_fire   = aw_held_r && w_held_r && !s_axi_bvalid;
    wr_idx    = word_index(aw_addr_r);
    wr_vreg   = (wr_idx < 6'(cmx_pkg::NUM_VREGS)) && !busy;
    wr_status = wr_idx == word_index(cmx_pkg::OFF_STATUS);
    wr_instr  = (wr_idx == word_index(cmx_pkg::OFF_INSTR)) && !busy;
    wr_mem    = wr_idx == word_index(cmx_pkg::OFF_MEMWORD);
    wr_ok     = wr_vreg || wr_status || wr_instr || wr_mem;
    wr_merged = merge(instr_r, w_data_r, w_strb_r);
  end

  // Write response follows the completed write.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cmx_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? cmx_pkg::RESP_OKAY : cmx_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Opcode decode of the instruction being issued.
  always_comb begin
    op_add    = wr_merged[15:0] == cmx_pkg::OPC_CADD;
    op_mac    = wr_merged[15:0] == cmx_pkg::OPC_CMAC;
    op_mac_ld = (wr_merged[15:0] == cmx_pkg::OPC_CMAC_LD) &&
                (wr_merged[31:28] == cmx_pkg::OPC_LD_HI);
    ld_dest   = instr_r[27:24];
  end

  // Instruction register and sequencer. The add finishes in one cycle; the
  // multiply-accumulate spends a second cycle landing its products.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      instr_r <= cmx_pkg::INSTR_RST;
      st_r    <= cmx_pkg::S_IDLE;
    end else begin
      case (st_r)
        cmx_pkg::S_IDLE: begin
          if (wr_fire && wr_instr) begin
            instr_r <= wr_merged;
            if (op_add) begin
              st_r <= cmx_pkg::S_ADD;
            end else if (op_mac || op_mac_ld) begin
              st_r <= cmx_pkg::S_MAC1;
            end
          end
        end
        cmx_pkg::S_ADD:  st_r <= cmx_pkg::S_IDLE;
        cmx_pkg::S_MAC1: st_r <= cmx_pkg::S_MAC2;
        cmx_pkg::S_MAC2: st_r <= cmx_pkg::S_IDLE;
        default:         st_r <= cmx_pkg::S_IDLE;
      endcase
    end
  end

  // Adder operands: upper quad for the add, accumulators for the MAC.
  always_comb begin
    if (st_r == cmx_pkg::S_ADD) begin
      acc_re = vreg_r[7];
      acc_im = vreg_r[6];
      add_re = vreg_r[5];
      add_im = vreg_r[4];
    end else begin
      acc_re = vreg_r[5];
      acc_im = vreg_r[4];
      add_re = vreg_r[3];
      add_im = vreg_r[2];
    end
  end

  cmx_shift_acc u_acc_re (
    .acc    (acc_re),
    .addend (add_re),
    .shift  (shift_r),
    .rnd_en (rnd_r),
    .sat_en (sat_r),
    .result (res_re),
    .ovf    (ovf_re)
  );

  cmx_shift_acc u_acc_im (
    .acc    (acc_im),
    .addend (add_im),
    .shift  (shift_r),
    .rnd_en (rnd_r),
    .sat_en (sat_r),
    .result (res_im),
    .ovf    (ovf_im)
  );

  // Signed 16x16 products of the packed halves of vreg0 and vreg1.
  always_comb begin
    p_hh = 32'($signed(vreg_r[0][31:16]) * $signed(vreg_r[1][31:16]));
    p_ll = 32'($signed(vreg_r[0][15:0]) * $signed(vreg_r[1][15:0]));
    p_hl = 32'($signed(vreg_r[0][31:16]) * $signed(vreg_r[1][15:0]));
    p_lh = 32'($signed(vreg_r[0][15:0]) * $signed(vreg_r[1][31:16]));
    sum_re = {p_hh[31], p_hh} + {p_ll[31], p_ll};
    if (pack_r) begin
      sum_im = {p_lh[31], p_lh} - {p_hl[31], p_hl};
    end else begin
      sum_im = {p_hl[31], p_hl} - {p_lh[31], p_lh};
    end
  end

  // Products are captured in the first MAC cycle and land in the second.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prod_re_r  <= cmx_pkg::VREG_RST;
      prod_im_r  <= cmx_pkg::VREG_RST;
      prod_ovr_r <= 1'b0;
      prod_ovi_r <= 1'b0;
    end else if (st_r == cmx_pkg::S_MAC1) begin
      prod_re_r  <= sat_r ? cmx_pkg::sat33(sum_re) : sum_re[31:0];
      prod_im_r  <= sat_r ? cmx_pkg::sat33(sum_im) : sum_im[31:0];
      prod_ovr_r <= sum_re[32] ^ sum_re[31];
      prod_ovi_r <= sum_im[32] ^ sum_im[31];
    end
  end

  // Vector register file. Software writes only reach it while idle.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < cmx_pkg::NUM_VREGS; i++) begin
        vreg_r[i] <= cmx_pkg::VREG_RST;
      end
    end else begin
      case (st_r)
        cmx_pkg::S_ADD: begin
          vreg_r[7] <= res_re;
          vreg_r[6] <= res_im;
        end
        cmx_pkg::S_MAC1: begin
          vreg_r[5] <= res_re;
          vreg_r[4] <= res_im;
          // A forbidden destination of vreg5 or vreg4 lets the load win.
          if ((instr_r[15:0] == cmx_pkg::OPC_CMAC_LD) &&
              (ld_dest < 4'(cmx_pkg::NUM_VREGS))) begin
            vreg_r[ld_dest] <= memword_r;
          end
        end
        cmx_pkg::S_MAC2: begin
          vreg_r[3] <= prod_re_r;
          vreg_r[2] <= prod_im_r;
        end
        default: begin
          if (wr_fire && wr_vreg) begin
            vreg_r[wr_idx[3:0]] <= merge(vreg_r[wr_idx[3:0]], w_data_r,
                                         w_strb_r);
          end
        end
      endcase
    end
  end

  // Memory operand word supplied by software for the parallel load.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      memword_r <= cmx_pkg::VREG_RST;
    end else if (wr_fire && wr_mem) begin
      memword_r <= merge(memword_r, w_data_r, w_strb_r);
    end
  end

  // Configuration fields of vector_status.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shift_r <= cmx_pkg::SHIFT_RST;
      rnd_r   <= 1'b0;
      sat_r   <= 1'b0;
      pack_r  <= 1'b0;
    end else if (wr_fire && wr_status && w_strb_r[0]) begin
      shift_r <= w_data_r[cmx_pkg::ST_SHIFT_LSB +: cmx_pkg::ST_SHIFT_W];
      rnd_r   <= w_data_r[cmx_pkg::ST_RND_BIT];
      sat_r   <= w_data_r[cmx_pkg::ST_SAT_BIT];
      pack_r  <= w_data_r[cmx_pkg::ST_PACK_BIT];
    end
  end

  // Sticky flags, cleared by writing one; a same-cycle set beats the clear.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      real_overflow_flag_r  <= 1'b0;
      imag_overflow_flag_r  <= 1'b0;
      badop_r <= 1'b0;
    end else begin
      real_overflow_flag_r <= ((st_r == cmx_pkg::S_ADD || st_r == cmx_pkg::S_MAC1) && ovf_re)
             || (st_r == cmx_pkg::S_MAC2 && prod_ovr_r)
             || (real_overflow_flag_r && !(wr_fire && wr_status && w_strb_r[1] &&
                             w_data_r[cmx_pkg::ST_REAL_OVERFLOW_FLAG_BIT]));
      imag_overflow_flag_r <= ((st_r == cmx_pkg::S_ADD || st_r == cmx_pkg::S_MAC1) && ovf_im)
             || (st_r == cmx_pkg::S_MAC2 && prod_ovi_r)
             || (imag_overflow_flag_r && !(wr_fire && wr_status && w_strb_r[1] &&
                             w_data_r[cmx_pkg::ST_IMAG_OVERFLOW_FLAG_BIT]));
      badop_r <= (wr_fire && wr_instr && !(op_add || op_mac || op_mac_ld))
              || (badop_r && !(wr_fire && wr_status && w_strb_r[1] &&
                               w_data_r[cmx_pkg::ST_BADOP_BIT]));
    end
  end

  // Read view of vector_status.
  always_comb begin
    status_view = 32'h0000_0000;
    status_view[cmx_pkg::ST_SHIFT_LSB +: cmx_pkg::ST_SHIFT_W] = shift_r;
    status_view[cmx_pkg::ST_RND_BIT]   = rnd_r;
    status_view[cmx_pkg::ST_SAT_BIT]   = sat_r;
    status_view[cmx_pkg::ST_PACK_BIT]  = pack_r;
    status_view[cmx_pkg::ST_REAL_OVERFLOW_FLAG_BIT]  = real_overflow_flag_r;
    status_view[cmx_pkg::ST_IMAG_OVERFLOW_FLAG_BIT]  = imag_overflow_flag_r;
    status_view[cmx_pkg::ST_BADOP_BIT] = badop_r;
    status_view[cmx_pkg::ST_BUSY_BIT]  = busy;
  end

  // Read channel; data is registered so it answers one cycle after arvalid.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cmx_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= cmx_pkg::RESP_OKAY;
      if (word_index(s_axi_araddr) < 6'(cmx_pkg::NUM_VREGS)) begin
        s_axi_rdata <= vreg_r[s_axi_araddr[5:2]];
      end else if (word_index(s_axi_araddr) ==
                   word_index(cmx_pkg::OFF_STATUS)) begin
        s_axi_rdata <= status_view;
      end else if (word_index(s_axi_araddr) ==
                   word_index(cmx_pkg::OFF_INSTR)) begin
        s_axi_rdata <= instr_r;
      end else if (word_index(s_axi_araddr) ==
                   word_index(cmx_pkg::OFF_MEMWORD)) begin
        s_axi_rdata <= memword_r;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= cmx_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ==== test/cmx_datapath_top_chk.sv ====
`timescale 1ns/1ps
// Watches the register port for handshake timing and the sticky real overflow flag.
module cmx_chk (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [7:0] aw_a_r;
  logic [7:0] ar_a_r;
  logic       seen_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Keep the address of each transfer so that its answer can be judged.
  always_ff @(posedge clk_sys) begin
    if (s_axi_awvalid && s_axi_awready)
      aw_a_r <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready)
      ar_a_r <= s_axi_araddr;
  end

  // Any status write may clear the flag, so it disarms the sticky check.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || (s_axi_awvalid && s_axi_awready &&
                    s_axi_awaddr == cmx_pkg::OFF_STATUS))
      seen_r <= 1'b0;
    else if (s_axi_rvalid && s_axi_rready &&
             ar_a_r == cmx_pkg::OFF_STATUS && s_axi_rdata[8])
      seen_r <= 1'b1;
  end

  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");

  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read answer moved");

  property p_ar_quiet;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_quiet: assert property (p_ar_quiet) else $error("read overlap");

  property p_rd_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2f |=>
      s_axi_rresp == cmx_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rd_bad: assert property (p_rd_bad) else $error("bad read accepted");

  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write answer moved");

  // Both halves are held first, so the answer shows one edge later still.
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      !s_axi_bvalid |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");

  property p_wr_bad;
    $rose(s_axi_bvalid) && aw_a_r > 8'h2f |->
      s_axi_bresp == cmx_pkg::RESP_SLVERR;
  endproperty
  a_wr_bad: assert property (p_wr_bad) else $error("bad write accepted");

  property p_sticky;
    s_axi_rvalid && ar_a_r == cmx_pkg::OFF_STATUS && seen_r |-> s_axi_rdata[8];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  c_add: cover property (s_axi_wvalid && s_axi_wdata[15:0] == 16'he52a);
  c_bad: cover property (s_axi_rvalid && s_axi_rresp != 2'b00);
  c_sticky: cover property (s_axi_rvalid && seen_r);
endmodule

bind cmx_datapath_top cmx_chk chk_u (
  .clk_sys       (clk_sys),
  .sys_rst       (sys_rst),
  .s_axi_awaddr  (s_axi_awaddr),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wdata   (s_axi_wdata),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready)
);

// ==== test/tb_cmx_datapath_top.sv ====
`timescale 1ns/1ps
// Self-checking bench for the complex add and conjugate multiply datapath.
module tb_cmx_datapath_top;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic [2:0]  prot = 3'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rdat;
  int          miscompares = 0;
  int          check_count = 0;

  // Free-running 200 MHz system clock.
  always #2.5 clk_sys = ~clk_sys;

  cmx_datapath_top dut_u (
    .clk_sys       (clk_sys),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (awaddr),
    .s_axi_awprot  (prot),
    .s_axi_awvalid (awvalid),
    .s_axi_awready (awready),
    .s_axi_wdata   (wdata),
    .s_axi_wstrb   (wstrb),
    .s_axi_wvalid  (wvalid),
    .s_axi_wready  (wready),
    .s_axi_bresp   (bresp),
    .s_axi_bvalid  (bvalid),
    .s_axi_bready  (bready),
    .s_axi_araddr  (araddr),
    .s_axi_arprot  (prot),
    .s_axi_arvalid (arvalid),
    .s_axi_arready (arready),
    .s_axi_rdata   (rdata),
    .s_axi_rresp   (rresp),
    .s_axi_rvalid  (rvalid),
    .s_axi_rready  (rready)
  );

  task automatic wrap_up;
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // Address and data go out together; bready rises on the same edge as the answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    @(posedge clk_sys);
    bready <= 1'b1;
    do @(posedge clk_sys); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    @(posedge clk_sys);
    rready <= 1'b1;
    do @(posedge clk_sys); while (!rvalid);
    rdat = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask

  // Shifted addend; the rounding bit is the last one shifted out.
  function automatic logic [31:0] sr(input logic [31:0] x,
                                     input logic [7:0] c);
    sr = $signed(x) >>> c[4:0];
    if (c[5] && c[4:0] != 5'h0)
      sr = sr + x[c[4:0] - 5'h1];
  endfunction

  function automatic logic [31:0] sat(input longint v, input logic s,
                                      inout logic o);
    if (v > 64'sh7fff_ffff || v < -64'sh8000_0000) begin
      o = 1'b1;
      if (s)
        return (v < 0) ? 32'h8000_0000 : 32'h7fff_ffff;
    end
    return v[31:0];
  endfunction

  // Writing ones to the flag bits clears them along with the new setup.
  task automatic set_cfg(input logic [7:0] c);
    wr(cmx_pkg::OFF_STATUS, {21'h0, 3'h7, c});
  endtask

  task automatic do_add(input logic [31:0] a7, a6, a5, a4,
                        input logic [7:0] c);
    logic [31:0] e7, e6;
    logic        o7, o6;
    o7 = 1'b0;
    o6 = 1'b0;
    e7 = sat(longint'($signed(a7)) + $signed(sr(a5, c)), c[6], o7);
    e6 = sat(longint'($signed(a6)) + $signed(sr(a4, c)), c[6], o6);
    wr(8'h1c, a7);
    wr(8'h18, a6);
    wr(8'h14, a5);
    wr(8'h10, a4);
    set_cfg(c);
    wr(cmx_pkg::OFF_INSTR, {16'h0, cmx_pkg::OPC_CADD});
    rdc(8'h1c, e7);
    rdc(8'h18, e6);
    rdc(cmx_pkg::OFF_STATUS, {22'h0, o6, o7, c});
  endtask

  task automatic do_mac(input logic [31:0] v0, v1, v2, v3, v4, v5,
                        input logic [7:0] c, input logic [31:0] ins);
    longint      h0, l0, h1, l1, re, im;
    logic [31:0] e5, e4, e3, e2;
    logic        o_r, o_i;
    o_r = 1'b0;
    o_i = 1'b0;
    h0 = $signed(v0[31:16]);
    l0 = $signed(v0[15:0]);
    h1 = $signed(v1[31:16]);
    l1 = $signed(v1[15:0]);
    re = h0 * h1 + l0 * l1;
    im = c[7] ? l0 * h1 - h0 * l1 : h0 * l1 - l0 * h1;
    e5 = sat(longint'($signed(v5)) + $signed(sr(v3, c)), c[6], o_r);
    e4 = sat(longint'($signed(v4)) + $signed(sr(v2, c)), c[6], o_i);
    e3 = sat(re, c[6], o_r);
    e2 = sat(im, c[6], o_i);
    wr(8'h00, v0);
    wr(8'h04, v1);
    wr(8'h08, v2);
    wr(8'h0c, v3);
    wr(8'h10, v4);
    wr(8'h14, v5);
    set_cfg(c);
    wr(cmx_pkg::OFF_MEMWORD, 32'h5a3c_0f96);
    wr(cmx_pkg::OFF_INSTR, ins);
    rdc(8'h14, e5);
    rdc(8'h10, e4);
    rdc(8'h0c, e3);
    rdc(8'h08, e2);
    rdc(cmx_pkg::OFF_STATUS, {22'h0, o_i, o_r, c});
    if (ins[31:28] == 4'h1)
      rdc({2'b00, ins[27:24], 2'b00}, 32'h5a3c_0f96);
  endtask

  // Unknown words and a wrong high nibble must do nothing but flag.
  task automatic t_bad;
    set_cfg(8'h00);
    wr(cmx_pkg::OFF_INSTR, 32'h0000_e50e);
    rdc(cmx_pkg::OFF_STATUS, 32'h0000_0400);
    set_cfg(8'h00);
    wr(cmx_pkg::OFF_MEMWORD, 32'h0123_4567);
    wr(cmx_pkg::OFF_INSTR, {8'h06, 8'h00, cmx_pkg::OPC_CMAC_LD});
    rdc(cmx_pkg::OFF_STATUS, 32'h0000_0400);
    rdc(8'h18, 32'h5a3c_0f96);
  endtask

  // A flag survives reads and writes that do not touch its byte lane.
  task automatic t_sticky;
    do_add(32'h7fff_ffff, 32'h0, 32'h1, 32'h0, 8'h00);
    wr(cmx_pkg::OFF_STATUS, 32'h0000_0345, 4'h1);
    rdc(cmx_pkg::OFF_STATUS, 32'h0000_0145);
    rdc(cmx_pkg::OFF_STATUS, 32'h0000_0145);
    wr(cmx_pkg::OFF_STATUS, 32'h0000_0100, 4'h2);
    rdc(cmx_pkg::OFF_STATUS, 32'h0000_0045);
  endtask

  task automatic t_map;
    for (int n = 0; n < 10; n++)
      rdc(8'(4 * n), 32'h0);
    wr(8'h30, 32'hffff_ffff);
    chk({30'h0, rsp}, {30'h0, cmx_pkg::RESP_SLVERR});
    rd(8'h30);
    chk({30'h0, rsp}, {30'h0, cmx_pkg::RESP_SLVERR});
    chk(rdat, 32'h0);
  endtask

  // Main sequence: reset, then every scenario in turn.
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_map();
    do_add(32'h64, 32'h10, 32'h18, 32'hffff_ffe8, 8'h24);
    do_add(32'h64, 32'h10, 32'h18, 32'hffff_ffe8, 8'h04);
    do_add(32'h7fff_fff0, 32'h8000_0005, 32'h100, 32'hffff_ff00,
           8'h00);
    do_add(32'h7fff_fff0, 32'h8000_0005, 32'h100, 32'hffff_ff00,
           8'h60);
    do_add(32'h1, 32'h2, 32'h4000_0000, 32'hc000_0000, 8'h3f);
    for (int p = 0; p < 2; p++)
      do_mac(32'h0003_fffe, 32'h0005_0007, 32'hffff_ffd2, 32'h20, 32'h1000,
             32'h2000, {p[0], 7'h22}, {16'h0, cmx_pkg::OPC_CMAC});
    do_mac(32'h8000_8000, 32'h8000_8000, 32'h0, 32'h0, 32'h0, 32'h0,
           8'h40, {16'h0, cmx_pkg::OPC_CMAC});
    do_mac(32'h0002_0003, 32'hfffc_0001, 32'h5, 32'h7, 32'h1, 32'h2,
           8'h01, {8'h16, 8'h00, cmx_pkg::OPC_CMAC_LD});
    do_mac(32'h0, 32'h0, 32'he, 32'hffff_fffb, 32'h3, 32'h5, 8'h00,
           {16'h0, cmx_pkg::OPC_CMAC});
    t_bad();
    t_sticky();
    wrap_up();
  end

  // Cuts a hang short; the whole run needs only about six hundred cycles.
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
